// ==== src/static_lane_steer.sv ====
// Purpose: Byte-lane steering between the system bus and static memory
// Assumes: Requests, config and beat completion come from logic on core_clk_i
// Notes: One request at a time; narrow memories take several beats
// ------------------------------------------------------------
// What this block does
// RULE1: LE byte write, 16-bit: address 01 selects 01 upper lane, 00 selects 10.
// RULE2: LE byte write, 16-bit, address 10: address bit high, selects 10, byte 23:16 low.
// RULE3: LE 32-bit writes pass straight; word 0000, half 1- 0011, half 0- 1100.
// RULE4: LE 32-bit byte writes: one select, 0111 1011 1101 1110 for 11 to 00.
// RULE5: BE 8-bit reads: word beats 11,10,01,00; halfword two beats; select held low.
// RULE6: BE 8-bit byte read: address equals request; byte lands at lane three minus address.
// RULE7: BE 16-bit word reads two beats 1 then 0; halfwords return swapped halves.
// RULE8: BE 16-bit byte reads: address bit from addr[1], selects 01,10,01,10 for 00 to 11.
// RULE9: Lane selects active low; pattern chosen from endianness and memory width.
// ------------------------------------------------------------
module static_lane_steer
    import static_lane_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // System request side
    input wire logic req_valid_i,
    input wire bus_req_type req_i,
    input wire lane_cfg_type cfg_i,
    output logic req_ready_o,
    // Response side
    output logic resp_valid_o,
    output logic [31:0] resp_rdata_o,
    // Timing engine side
    input wire logic xfer_done_i,
    input wire logic [31:0] ext_mem_data_bus_i,
    output logic xfer_valid_o,
    output logic xfer_write_o,
    output logic ext_mem_data_oe_o,
    output logic [1:0] ext_mem_addr_out_o,
    output logic [3:0] ext_lane_select_n_o,
    output logic [31:0] ext_mem_data_bus_o
);

    typedef enum logic {ST_IDLE, ST_XFER} state_type;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_type state_q;
    bus_req_type req_q;
    lane_cfg_type cfg_q;
    logic [1:0] beat_q;
    logic [1:0] last_q;
    logic [3:0][1:0] map_q;
    logic [31:0] acc_q;
    logic [31:0] acc_d;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    wire take = (state_q == ST_IDLE) & req_valid_i;
    wire step = (state_q == ST_XFER) & xfer_done_i;
    wire final_beat = step & (beat_q == last_q);
    wire load = take | (step & ~final_beat);
    wire lane_cfg_type dec_cfg = take ? cfg_i : cfg_q;
    wire bus_req_type dec_req = take ? req_i : req_q;
    wire [1:0] dec_beat = take ? BEAT_FIRST : 2'(beat_q + 2'h1);
    wire [1:0] dec_addr;
    wire [3:0] dec_lane_n;
    wire [3:0][1:0] dec_map;
    wire [31:0] dec_wdata;
    wire [1:0] last_d;

    // RULE5 beat count per width
    assign last_d = (cfg_i.width == MEM_W8 && req_i.size == SIZE_WORD) ? LAST_BEAT_4 :
                    ((cfg_i.width == MEM_W8 && req_i.size == SIZE_HALF) ||
                     (cfg_i.width == MEM_W16 && req_i.size == SIZE_WORD)) ? LAST_BEAT_2 :
                    LAST_BEAT_1;

    // RULE9 pattern from config
    lane_map u_map (
        .cfg_i(dec_cfg),
        .size_i(dec_req.size),
        .addr_i(dec_req.addr),
        .beat_i(dec_beat),
        .ext_addr_o(dec_addr),
        .lane_n_o(dec_lane_n),
        .sys_lane_o(dec_map)
    );

    // Write data: each external lane takes the system byte it maps to
    for (genvar j = 0; j < LANES; j++)
    begin : g_wlane
        // RULE2 system byte onto lane
        assign dec_wdata[j*8 +: 8] = dec_req.wdata[dec_map[j]*8 +: 8];
    end

    // Read gather: enabled lanes land on their mapped system byte
    always_comb
    begin
        acc_d = take ? 32'h0000_0000 : acc_q;
        if (step)
        begin
            for (int j = 0; j < LANES; j++)
            begin
                // RULE8 read lane return
                if (!ext_lane_select_n_o[j])
                begin
                    acc_d[map_q[j]*8 +: 8] = ext_mem_data_bus_i[j*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Request hold and beat counter
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            req_q <= '0;
            cfg_q <= '0;
            beat_q <= BEAT_FIRST;
            last_q <= LAST_BEAT_1;
            acc_q <= 32'h0000_0000;
        end
        else
        begin
            acc_q <= acc_d;
            if (take)
            begin
                state_q <= ST_XFER;
                req_q <= req_i;
                cfg_q <= cfg_i;
                beat_q <= BEAT_FIRST;
                last_q <= last_d;
            end
            else if (final_beat)
            begin
                state_q <= ST_IDLE;
            end
            else if (step)
            begin
                beat_q <= 2'(beat_q + 2'h1);
            end
        end
    end

    // Registered outputs towards the memory and the system
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            req_ready_o <= 1'b1;
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 32'h0000_0000;
            xfer_valid_o <= 1'b0;
            xfer_write_o <= 1'b0;
            ext_mem_data_oe_o <= 1'b0;
            ext_mem_addr_out_o <= 2'h0;
            ext_lane_select_n_o <= LANES_IDLE_N;
            ext_mem_data_bus_o <= 32'h0000_0000;
            map_q <= '0;
        end
        else
        begin
            req_ready_o <= final_beat | (req_ready_o & ~take);
            resp_valid_o <= final_beat;
            if (final_beat)
            begin
                resp_rdata_o <= acc_d;
                xfer_valid_o <= 1'b0;
                ext_mem_data_oe_o <= 1'b0;
                ext_lane_select_n_o <= LANES_IDLE_N;
            end
            else if (load)
            begin
                // RULE3 beat outputs
                xfer_valid_o <= 1'b1;
                xfer_write_o <= dec_req.write;
                ext_mem_data_oe_o <= dec_req.write;
                ext_mem_addr_out_o <= dec_addr;
                ext_lane_select_n_o <= dec_lane_n;
                ext_mem_data_bus_o <= dec_wdata;
                map_q <= dec_map;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire le16 = ~cfg_i.big_endian & (cfg_i.width == MEM_W16);
    wire be16 = cfg_i.big_endian & (cfg_i.width == MEM_W16);
    wire le32 = ~cfg_i.big_endian & (cfg_i.width == MEM_W32);
    wire be8 = cfg_i.big_endian & (cfg_i.width == MEM_W8);
    wire [7:0] resp_pick = resp_rdata_o[{~req_q.addr, 3'b000} +: 8];

    a_le16_byte_odd: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE1
        take && le16 && req_i.write && req_i.size == SIZE_BYTE && req_i.addr == 2'h1
        |=> ext_lane_select_n_o == 4'hd && ext_mem_addr_out_o == 2'h0
            && ext_mem_data_bus_o[15:8] == $past(req_i.wdata[15:8]))
        else $error("LE 16-bit byte write at 01 misplaced");
    a_le16_byte_high: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE2
        take && le16 && req_i.write && req_i.size == SIZE_BYTE && req_i.addr == 2'h2
        |=> ext_lane_select_n_o == 4'he && ext_mem_addr_out_o == 2'h1
            && ext_mem_data_bus_o[7:0] == $past(req_i.wdata[23:16]))
        else $error("LE 16-bit byte write at 10 misplaced");
    a_le32_word_all: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE3
        take && le32 && req_i.write && req_i.size == SIZE_WORD
        |=> ext_lane_select_n_o == 4'h0 && ext_mem_data_bus_o == $past(req_i.wdata))
        else $error("LE 32-bit word write not straight through");
    a_le32_byte_one: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE4
        take && le32 && req_i.size == SIZE_BYTE
        |=> $countones(~ext_lane_select_n_o) == 1
            && !ext_lane_select_n_o[$past(req_i.addr)])
        else $error("LE 32-bit byte select wrong");
    a_be8_word_walk: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE5
        step && !final_beat && cfg_q.big_endian && cfg_q.width == MEM_W8
        && req_q.size == SIZE_WORD
        |=> ext_mem_addr_out_o == 2'($past(ext_mem_addr_out_o) - 2'h1)
            && ext_lane_select_n_o[0] == 1'b0)
        else $error("BE 8-bit word beat order broken");
    a_be8_byte_ret: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE6
        final_beat && cfg_q.big_endian && cfg_q.width == MEM_W8
        && req_q.size == SIZE_BYTE && !req_q.write
        |=> resp_valid_o && resp_pick == $past(ext_mem_data_bus_i[7:0]))
        else $error("BE 8-bit byte read landed on wrong lane");
    a_be16_word_first: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE7
        take && be16 && !req_i.write && req_i.size == SIZE_WORD
        |=> ext_mem_addr_out_o == 2'h1 && ext_lane_select_n_o == 4'hc)
        else $error("BE 16-bit word first beat wrong");
    a_be16_byte_sel: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE8
        take && be16 && !req_i.write && req_i.size == SIZE_BYTE
        |=> ext_mem_addr_out_o[0] == $past(req_i.addr[1])
            && ext_lane_select_n_o[1:0] == ($past(req_i.addr[0]) ? 2'b10 : 2'b01))
        else $error("BE 16-bit byte select wrong");
    a_idle_lanes_off: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE9
        !xfer_valid_o |-> ext_lane_select_n_o == LANES_IDLE_N && !ext_mem_data_oe_o)
        else $error("Lane selected with no transfer");

endmodule

// ==== src/static_lane_pkg.sv ====
// Purpose: Shared types and constants for the static memory byte-lane steering block
// Assumes: 32-bit system data, external memory 8, 16 or 32 bits wide
// Notes: Lane selects are active low throughout
package static_lane_pkg;

    // ------------------------------------------------------------
    // Sizes, widths and lane constants
    // ------------------------------------------------------------
    localparam int LANES = 4;
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [3:0] LANES_IDLE_N = 4'hf;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] LAST_BEAT_4 = 2'h3;
    localparam logic [1:0] LAST_BEAT_2 = 2'h1;
    localparam logic [1:0] LAST_BEAT_1 = 2'h0;

    typedef enum logic [1:0] {
        MEM_W8 = 2'h0,
        MEM_W16 = 2'h1,
        MEM_W32 = 2'h2
    } mem_width_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [2:0] size;
        logic [1:0] addr;
        logic [31:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic big_endian;
        mem_width_type width;
    } lane_cfg_type;

endpackage

// ==== src/lane_map.sv ====
// Purpose: Per-beat external address, lane selects and lane-to-system byte map
// Assumes: Purely combinational, inputs stable for the beat being decoded
// Notes: Each external lane gets the byte address it carries, then hit and target lane
module lane_map
    import static_lane_pkg::*;
(
    // Access description
    input wire lane_cfg_type cfg_i,
    input wire logic [2:0] size_i,
    input wire logic [1:0] addr_i,
    input wire logic [1:0] beat_i,
    // Decoded beat
    output logic [1:0] ext_addr_o,
    output logic [3:0] lane_n_o,
    output logic [3:0][1:0] sys_lane_o
);

    // ------------------------------------------------------------
    // Beat address per memory width
    // ------------------------------------------------------------
    wire w8 = (cfg_i.width == MEM_W8);
    wire w16 = (cfg_i.width == MEM_W16);
    wire is_word = (size_i == SIZE_WORD);
    wire is_half = (size_i == SIZE_HALF);
    wire [1:0] beat_addr8;
    wire [1:0] beat_addr16;

    // Narrow beats walk down from the top byte address
    assign beat_addr8 = is_word ? 2'(LAST_BEAT_4 - beat_i) :
                        is_half ? {addr_i[1], ~beat_i[0]} : addr_i;
    // RULE7 16-bit beat address
    assign beat_addr16 = {1'b0, is_word ? ~beat_i[0] : addr_i[1]};
    assign ext_addr_o = w8 ? beat_addr8 : (w16 ? beat_addr16 : 2'h0);

    // ------------------------------------------------------------
    // Per external lane decode
    // ------------------------------------------------------------
    for (genvar j = 0; j < LANES; j++)
    begin : g_lane
        localparam logic [1:0] LANE_IDX = 2'(j);
        wire [1:0] byte_addr;
        wire present;
        wire hit;
        // Byte address carried by this lane in the current beat
        assign byte_addr = w8 ? beat_addr8 :
                           w16 ? {beat_addr16[0], cfg_i.big_endian ? ~LANE_IDX[0] : LANE_IDX[0]} :
                           (cfg_i.big_endian ? ~LANE_IDX : LANE_IDX);
        // RULE1 lanes within width
        assign present = w8 ? (j == 0) : (w16 ? (j < 2) : 1'b1);
        // RULE4 single lane hit
        assign hit = is_word | (is_half & (byte_addr[1] == addr_i[1])) | (byte_addr == addr_i);
        // RULE9 active low select
        assign lane_n_o[j] = ~(present & hit);
        // RULE6 big endian reverses lanes
        assign sys_lane_o[j] = cfg_i.big_endian ? ~byte_addr : byte_addr;
    end

endmodule

// ==== sim/ext_mem_model.sv ====
// Purpose: Timing engine and static memory stand-in for the lane steering bench
// Assumes: One beat at a time, handshake on core_clk_i
// Notes: Read bytes encode lane and address, so a misrouted byte shows up
module ext_mem_model
    import static_lane_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Beat side
    input wire logic xfer_valid_i,
    input wire logic xfer_write_i,
    input wire logic data_oe_i,
    input wire logic [1:0] addr_i,
    input wire logic [3:0] lane_n_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wait_i,
    output logic done_o,
    output logic [31:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic [31:0] pat;
    logic [39:0] log[$];
    // Beat ends once the wait count is reached; zero wait ends it at once
    assign done_o = xfer_valid_i && (cnt_q == wait_i);
    // Each lane byte carries its lane number plus one and the beat address
    assign pat = {4'h4, 2'h0, addr_i, 4'h3, 2'h0, addr_i, 4'h2, 2'h0, addr_i, 4'h1, 2'h0, addr_i};
    // Off the done cycle the bus shows inverted data, never a stale copy
    assign rdata_o = done_o ? pat : ~pat;
    // Count wait cycles and log each finished beat
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            cnt_q <= 4'h0;
        else if (done_o)
        begin
            cnt_q <= 4'h0;
            log.push_back({xfer_write_i, data_oe_i, addr_i, lane_n_i, wdata_i});
        end
        else if (xfer_valid_i)
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ==== sim/test_static_lane_steer.sv ====
// Purpose: Self-checking bench for the static memory byte-lane steering block
// Assumes: Engine model answers each beat after a chosen wait
// Notes: Write data is judged on selected lanes only
module test_static_lane_steer import static_lane_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] wd = 32'ha1b2_c3d4;
    logic core_clk_i, reset_i, req_valid_i, req_ready_o, resp_valid_o, xfer_done_i;
    logic xfer_valid_o, xfer_write_o, ext_mem_data_oe_o;
    bus_req_type req_i;
    lane_cfg_type cfg_i;
    logic [31:0] resp_rdata_o, ext_mem_data_bus_i, ext_mem_data_bus_o;
    logic [1:0] ext_mem_addr_out_o;
    logic [3:0] ext_lane_select_n_o, wait_q;
    int num_errors = 0;
    int n_compared = 0;
    // Block under test and the far side
    static_lane_steer static_lane_steer_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .cfg_i(cfg_i), .req_ready_o(req_ready_o),
        .resp_valid_o(resp_valid_o), .resp_rdata_o(resp_rdata_o), .xfer_done_i(xfer_done_i),
        .ext_mem_data_bus_i(ext_mem_data_bus_i), .xfer_valid_o(xfer_valid_o),
        .xfer_write_o(xfer_write_o), .ext_mem_data_oe_o(ext_mem_data_oe_o),
        .ext_mem_addr_out_o(ext_mem_addr_out_o), .ext_lane_select_n_o(ext_lane_select_n_o),
        .ext_mem_data_bus_o(ext_mem_data_bus_o));
    ext_mem_model ext_mem_model_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .xfer_valid_i(xfer_valid_o), .xfer_write_i(xfer_write_o), .data_oe_i(ext_mem_data_oe_o),
        .addr_i(ext_mem_addr_out_o), .lane_n_i(ext_lane_select_n_o),
        .wdata_i(ext_mem_data_bus_o), .wait_i(wait_q), .done_o(xfer_done_i),
        .rdata_o(ext_mem_data_bus_i));
    // Clock, 8 ns period
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request: present until taken, then wait for the response pulse
    task automatic do_req(input logic w, input logic [2:0] sz, input logic [1:0] a,
        input logic be, input mem_width_type mw, input int n, input logic [31:0] exp_rd);
        int k;
        ext_mem_model_inst.log.delete();
        req_i = '{write: w, size: sz, addr: a, wdata: wd};
        cfg_i = '{big_endian: be, width: mw};
        req_valid_i = 1'b1;
        for (k = 0; k < 50 && req_ready_o !== 1'b1; k++)
            @(posedge core_clk_i) #1;
        chk("ready_wait", req_ready_o, 1'b1);
        @(posedge core_clk_i) #1;
        req_valid_i = 1'b0;
        chk("ready_busy", req_ready_o, 1'b0);
        chk("beat_start", xfer_valid_o, 1'b1);
        for (k = 0; k < 200 && resp_valid_o !== 1'b1; k++)
            @(posedge core_clk_i) #1;
        chk("resp_valid", resp_valid_o, 1'b1);
        chk("beat_count", ext_mem_model_inst.log.size(), n);
        if (!w)
            chk("rdata", resp_rdata_o, exp_rd);
    endtask
    // Judge one logged beat
    task automatic beat(input int i, input logic w, input logic [1:0] a, input logic [3:0] sel);
        logic [39:0] e;
        logic [31:0] m;
        e = (i < ext_mem_model_inst.log.size()) ? ext_mem_model_inst.log[i] : 'x;
        m = {{8{~sel[3]}}, {8{~sel[2]}}, {8{~sel[1]}}, {8{~sel[0]}}};
        chk("beat_write", e[39:38], {w, w});
        chk("beat_addr", e[37:36], a);
        chk("beat_sel", e[35:32], sel);
        if (w)
            chk("beat_data", e[31:0] & m, wd & m);
    endtask
    task automatic idle_check();
        chk("ready_idle", req_ready_o, 1'b1);
        chk("lanes_idle", ext_lane_select_n_o, LANES_IDLE_N);
        chk("xfer_idle", xfer_valid_o, 1'b0);
        chk("resp_idle", resp_valid_o, 1'b0);
    endtask
    // Little-endian byte writes to 16-bit memory, data checked by lane
    task automatic le16_writes();
        logic [31:0] d;
        wait_q = 4'h0;
        for (int a = 0; a < 4; a++)
        begin
            do_req(1'b1, SIZE_BYTE, 2'(a), 1'b0, MEM_W16, 1, 32'h0);
            d = ext_mem_model_inst.log.size() > 0 ? ext_mem_model_inst.log[0][31:0] : 'x;
            chk("beat_sel", ext_mem_model_inst.log[0][35:32], a[0] ? 4'hd : 4'he);
            chk("beat_addr", ext_mem_model_inst.log[0][37:36], {1'b0, a[1]});
            chk("beat_lane", a[0] ? d[15:8] : d[7:0], wd[8 * a +: 8]);
        end
    endtask
    // Little-endian 32-bit writes with a slow engine
    task automatic le32_writes();
        wait_q = 4'h3;
        do_req(1'b1, SIZE_WORD, 2'h0, 1'b0, MEM_W32, 1, 32'h0);
        beat(0, 1'b1, 2'h0, 4'h0);
        do_req(1'b1, SIZE_HALF, 2'h2, 1'b0, MEM_W32, 1, 32'h0);
        beat(0, 1'b1, 2'h0, 4'h3);
        do_req(1'b1, SIZE_HALF, 2'h0, 1'b0, MEM_W32, 1, 32'h0);
        beat(0, 1'b1, 2'h0, 4'hc);
        for (int a = 0; a < 4; a++)
        begin
            do_req(1'b1, SIZE_BYTE, 2'(a), 1'b0, MEM_W32, 1, 32'h0);
            beat(0, 1'b1, 2'h0, ~(4'h1 << a));
        end
    endtask
    // Big-endian reads from 8-bit memory, back to back
    task automatic be8_reads();
        wait_q = 4'h1;
        do_req(1'b0, SIZE_WORD, 2'h0, 1'b1, MEM_W8, 4, 32'h1011_1213);
        for (int i = 0; i < 4; i++)
            beat(i, 1'b0, 2'(3 - i), 4'he);
        do_req(1'b0, SIZE_HALF, 2'h2, 1'b1, MEM_W8, 2, 32'h0000_1213);
        beat(1, 1'b0, 2'h2, 4'he);
        do_req(1'b0, SIZE_HALF, 2'h0, 1'b1, MEM_W8, 2, 32'h1011_0000);
        beat(0, 1'b0, 2'h1, 4'he);
        for (int a = 0; a < 4; a++)
        begin
            do_req(1'b0, SIZE_BYTE, 2'(a), 1'b1, MEM_W8, 1, (32'h10 | a) << (8 * (3 - a)));
            beat(0, 1'b0, 2'(a), 4'he);
        end
    endtask
    // Big-endian reads from 16-bit memory
    task automatic be16_reads();
        logic [1:0] la;
        wait_q = 4'h0;
        do_req(1'b0, SIZE_WORD, 2'h0, 1'b1, MEM_W16, 2, 32'h2010_2111);
        beat(0, 1'b0, 2'h1, 4'hc);
        beat(1, 1'b0, 2'h0, 4'hc);
        do_req(1'b0, SIZE_HALF, 2'h2, 1'b1, MEM_W16, 1, 32'h0000_2111);
        do_req(1'b0, SIZE_HALF, 2'h0, 1'b1, MEM_W16, 1, 32'h2010_0000);
        beat(0, 1'b0, 2'h0, 4'hc);
        for (int a = 0; a < 4; a++)
        begin
            la = 2'(a);
            do_req(1'b0, SIZE_BYTE, la, 1'b1, MEM_W16, 1,
                {24'h0, la[0] ? 4'h1 : 4'h2, 3'h0, la[1]} << (8 * (3 - a)));
            beat(0, 1'b0, {1'b0, la[1]}, la[0] ? 4'he : 4'hd);
        end
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        num_errors++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        reset_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        cfg_i = '0;
        wait_q = 4'h0;
        repeat (20) @(posedge core_clk_i);
        #1;
        reset_i = 1'b0;
        idle_check();
        le16_writes();
        le32_writes();
        be8_reads();
        be16_reads();
        @(posedge core_clk_i) #1;
        idle_check();
        wrap_up();
    end
endmodule
